// >>> dtim_channel.sv
/*
 * one 16-bit interval timer: counter, match buffer and toggle output.
 * assumes tick inputs are one-cycle pulses in the pclk domain.
 */
`timescale 1ns/1ps
module dtim_channel (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        run,
   input  wire logic        clk_sel,
   input  wire logic        psc_match,
   input  wire logic [15:0] match_regs,
   output logic             match,
   output logic             out_pin
);

   logic [15:0] count;
   logic [15:0] match_buf;
   logic        tick;

   // ----------------------------------------
   // count source and match
   // ----------------------------------------
   assign tick  = run & (clk_sel ? psc_match : 1'b1); // [R1] [R2]
   assign match = tick & (count == match_buf);         // [R5] [R7]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
      end else if (ce) begin
         if (!run) begin
            count <= 16'h0000;        // [R6] [R3] [R4]
         end else if (match) begin
            count <= 16'h0000;        // [R6]
         end else if (tick) begin
            count <= count + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // match buffer
   // ----------------------------------------
   // while running, reload only at match so a mid-period write cannot shorten the period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_buf <= 16'h0000;
      end else if (ce) begin
         if (!run || match) begin
            match_buf <= match_regs;  // [R8] [R9] [R10]
         end
      end
   end

   // ----------------------------------------
   // toggle output
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_pin <= 1'b1;
      end else if (ce) begin
         if (!run) begin
            out_pin <= 1'b1;          // [R12] [R13]
         end else if (match) begin
            out_pin <= ~out_pin;      // [R12] [R13] [R7]
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   stop_clears_a: assert property (ce && !run |=> count == 16'h0000) // [R6]
      else $error("counter not cleared while stopped");
   stop_high_a: assert property (ce && !run |=> out_pin) // [R12]
      else $error("output not high while stopped");
   match_toggle_a: assert property (ce && match |=> out_pin != $past(out_pin)) // [R13]
      else $error("output did not toggle on match");
   match_equal_a: assert property (match |-> count == match_buf) // [R5]
      else $error("match without equal count");
   buffer_follow_a: assert property (ce && !run |=> match_buf == $past(match_regs)) // [R8]
      else $error("stopped buffer does not follow registers");
   buffer_hold_a: assert property (run && !match |=> $stable(match_buf)) // [R9]
      else $error("running buffer changed without match");
   source_gate_a: assert property (run && clk_sel && !psc_match |=> $stable(count)) // [R1]
      else $error("counter moved without prescaler pulse");

endmodule

// >>> dtim_pkg.sv
/*
 * constants for the dual 16-bit interval timer block: register indices,
 * field positions, reset values and prescaler source codes.
 * assumes an apb master on the cpu side; byte address is four times the index.
 */
// Summary of operation
// R1: control bit 2 picks first timer source: system clock or prescaler match
// R2: control bit 6 picks second timer source: system clock or prescaler match
// R3: control bit 3 runs the first timer when 1, stops it when 0
// R4: control bit 7 runs the second timer when 1, stops it when 0
// R5: each timer pulses match when its count equals its match buffer
// R6: counter held at zero while stopped and restarts from zero after match
// R7: period is match value plus one counts; output period is twice that
// R8: a stopped timer's match buffer follows its high and low match registers
// R9: a running first timer reloads its buffer only on match
// R10: a running second timer reloads its buffer only on match
// R11: software writes match registers at most once per period on slow sources
// R12: first output pin high while stopped, toggles on each match while running
// R13: second output pin high while stopped, toggles on each match while running
// R14: each timer may request an interrupt once per period when enabled
// R15: prescaler runs while either clock-select bit is 1, else stops and clears
// R16: prescaler source: 00 system clock, 01 none, 10 first osc, 11 second osc
// R17: 4-bit prescaler pulses on reaching its match value and restarts at zero
// R18: prescaler period field is bits 7 to 4; period is field plus one
// R19: first timer flag bit 1 set on match, cleared by write; irq with bit 0
// R20: second timer flag bit 5 set on match, cleared by write; irq with bit 4
// R21: software changes a clock-select bit only while that timer is stopped
// R22: interrupt request stays high while flag and enable are both 1
package dtim_pkg;

   // ----------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------
   localparam logic [15:0] IDX_FIRST_MATCH_LOW   = 16'h7fa0;
   localparam logic [15:0] IDX_FIRST_MATCH_HIGH  = 16'h7fa1;
   localparam logic [15:0] IDX_SECOND_MATCH_LOW  = 16'h7fa2;
   localparam logic [15:0] IDX_SECOND_MATCH_HIGH = 16'h7fa3;
   localparam logic [15:0] IDX_CONTROL           = 16'h7fa4;
   localparam logic [15:0] IDX_CLOCK_SETTING     = 16'h7fb6;
   localparam int          ADDR_W                = 18;

   // ----------------------------------------
   // control register fields, per timer at base 0 or 4
   // ----------------------------------------
   localparam int CTL_STRIDE = 4;
   localparam int CTL_IE     = 0;
   localparam int CTL_FLAG   = 1;
   localparam int CTL_CKSL   = 2;
   localparam int CTL_RUN    = 3;

   // ----------------------------------------
   // clock setting register fields
   // ----------------------------------------
   localparam int CLK_PWM_BIT = 0;
   localparam int CLK_SEL_LO  = 2;
   localparam int CLK_PER_LO  = 4;

   localparam logic [1:0] PSC_SRC_SYSCLK  = 2'h0;
   localparam logic [1:0] PSC_SRC_INHIBIT = 2'h1;
   localparam logic [1:0] PSC_SRC_FIRST_OSCILLATOR    = 2'h2;
   localparam logic [1:0] PSC_SRC_SECOND_OSCILLATOR    = 2'h3;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_MATCH   = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_CLOCK   = 8'h00;
   localparam logic [3:0] RST_PSC     = 4'h0;

endpackage

// >>> dtim_top.sv
/*
 * dual 16-bit interval timers with shared 4-bit prescaler behind an apb slave.
 * assumes oscillator inputs are synchronous levels; one edge counted per rise.
 */
// Our own choice: register access over APB.
`timescale 1ns/1ps
module dtim_top (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       ce,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dtim_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       first_oscillator,
   input  wire logic                       second_oscillator,
   output logic                            first_timer_output_pin,
   output logic                            second_timer_output_pin,
   output logic                            first_timer_irq,
   output logic                            second_timer_irq
);

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [7:0] match_low  [2];
   logic [7:0] match_high [2];
   logic [7:0] control;
   logic [7:0] clock_setting;

   logic [3:0] psc_count;
   logic       psc_run;
   logic       psc_tick;
   logic       psc_match;
   logic       first_oscillator_q;
   logic       second_oscillator_q;
   logic [1:0] psc_src;
   logic [3:0] psc_period;

   logic [1:0] tmr_match;
   logic [1:0] tmr_out;
   logic [1:0] tmr_run;
   logic [1:0] tmr_cksl;
   logic [1:0] tmr_flag;
   logic [1:0] tmr_ie;
   logic [1:0] flag_clr;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic        word_ok;
   logic [15:0] idx;
   logic        hit_low0;
   logic        hit_high0;
   logic        hit_low1;
   logic        hit_high1;
   logic        hit_ctl;
   logic        hit_clk;
   logic        mapped;
   logic        setup;
   logic        wr_en;
   logic [7:0]  wbyte;
   logic [7:0]  next_rdata;

   assign word_ok   = (paddr[1:0] == 2'h0);
   assign idx       = paddr[17:2];
   assign hit_low0  = word_ok && idx == dtim_pkg::IDX_FIRST_MATCH_LOW;
   assign hit_high0 = word_ok && idx == dtim_pkg::IDX_FIRST_MATCH_HIGH;
   assign hit_low1  = word_ok && idx == dtim_pkg::IDX_SECOND_MATCH_LOW;
   assign hit_high1 = word_ok && idx == dtim_pkg::IDX_SECOND_MATCH_HIGH;
   assign hit_ctl   = word_ok && idx == dtim_pkg::IDX_CONTROL;
   assign hit_clk   = word_ok && idx == dtim_pkg::IDX_CLOCK_SETTING;
   assign mapped    = hit_low0 | hit_high0 | hit_low1 | hit_high1 | hit_ctl | hit_clk;

   // one wait-free access phase; a held-low clock enable stalls the bus too
   assign setup   = psel & ~penable;
   assign pready  = ce;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en   = ce & psel & penable & pwrite & mapped & pstrb[0];
   assign wbyte   = pwdata[7:0];

   always_comb begin
      next_rdata = 8'h00;
      if (hit_low0) begin
         next_rdata = match_low[0];
      end else if (hit_high0) begin
         next_rdata = match_high[0];
      end else if (hit_low1) begin
         next_rdata = match_low[1];
      end else if (hit_high1) begin
         next_rdata = match_high[1];
      end else if (hit_ctl) begin
         next_rdata = control;
      end else if (hit_clk) begin
         next_rdata = clock_setting;
      end
   end

   // read data captured in the setup cycle so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && setup) begin
         prdata <= {24'h00_0000, next_rdata};
      end
   end

   // ----------------------------------------
   // match data registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_low[0]  <= dtim_pkg::RST_MATCH;
         match_high[0] <= dtim_pkg::RST_MATCH;
         match_low[1]  <= dtim_pkg::RST_MATCH;
         match_high[1] <= dtim_pkg::RST_MATCH;
      end else if (wr_en) begin
         if (hit_low0) begin
            match_low[0] <= wbyte;
         end
         if (hit_high0) begin
            match_high[0] <= wbyte;
         end
         if (hit_low1) begin
            match_low[1] <= wbyte;
         end
         if (hit_high1) begin
            match_high[1] <= wbyte;
         end
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   // flags: written 0 clears, written 1 keeps; a match in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= dtim_pkg::RST_CONTROL;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (wr_en && hit_ctl) begin
               control[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_IE] <=
                  wbyte[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_IE];
               control[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_CKSL] <=
                  wbyte[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_CKSL];
               control[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_RUN] <=
                  wbyte[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_RUN];
            end
            if (tmr_match[i]) begin
               control[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_FLAG] <= 1'b1; // [R19] [R20]
            end else if (wr_en && hit_ctl
                         && !wbyte[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_FLAG]) begin
               control[i*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_FLAG] <= 1'b0; // [R19] [R20]
            end
         end
      end
   end

   // ----------------------------------------
   // clock setting register
   // ----------------------------------------
   // bit 1 does not exist and always reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_setting <= dtim_pkg::RST_CLOCK;
      end else if (wr_en && hit_clk) begin
         clock_setting <= {wbyte[7:2], 1'b0, wbyte[dtim_pkg::CLK_PWM_BIT]};
      end
   end

   assign psc_src    = clock_setting[dtim_pkg::CLK_SEL_LO +: 2];
   assign psc_period = clock_setting[dtim_pkg::CLK_PER_LO +: 4]; // [R18]

   // ----------------------------------------
   // shared prescaler
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_oscillator_q <= 1'b0;
         second_oscillator_q <= 1'b0;
      end else if (ce) begin
         first_oscillator_q <= first_oscillator;
         second_oscillator_q <= second_oscillator;
      end
   end

   assign psc_run = tmr_cksl[0] | tmr_cksl[1]; // [R15]

   always_comb begin
      unique case (psc_src)
         dtim_pkg::PSC_SRC_SYSCLK:  psc_tick = 1'b1;                  // [R16]
         dtim_pkg::PSC_SRC_INHIBIT: psc_tick = 1'b0;                  // [R16]
         dtim_pkg::PSC_SRC_FIRST_OSCILLATOR:    psc_tick = first_oscillator & ~first_oscillator_q;  // [R16]
         dtim_pkg::PSC_SRC_SECOND_OSCILLATOR:    psc_tick = second_oscillator & ~second_oscillator_q; // [R16]
      endcase
   end

   assign psc_match = psc_run & psc_tick & (psc_count == psc_period); // [R17] [R18]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_count <= dtim_pkg::RST_PSC;
      end else if (ce) begin
         if (!psc_run || psc_match) begin
            psc_count <= dtim_pkg::RST_PSC;   // [R15] [R17]
         end else if (psc_tick) begin
            psc_count <= psc_count + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // timer channels
   // ----------------------------------------
   // clock select is only meant to change while stopped; not enforced here
   for (genvar g = 0; g < 2; g++) begin : g_tmr
      assign tmr_ie[g]   = control[g*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_IE];
      assign tmr_flag[g] = control[g*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_FLAG];
      assign tmr_cksl[g] = control[g*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_CKSL]; // [R1] [R2]
      assign tmr_run[g]  = control[g*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_RUN];  // [R3] [R4]
      assign flag_clr[g] = wr_en & hit_ctl & ~wbyte[g*dtim_pkg::CTL_STRIDE+dtim_pkg::CTL_FLAG];

      dtim_channel u_chan (
         .pclk       (pclk),
         .presetn    (presetn),
         .ce         (ce),
         .run        (tmr_run[g]),
         .clk_sel    (tmr_cksl[g]),
         .psc_match  (psc_match),
         .match_regs ({match_high[g], match_low[g]}),
         .match      (tmr_match[g]),
         .out_pin    (tmr_out[g])
      );
   end

   assign first_timer_output_pin  = tmr_out[0];
   assign second_timer_output_pin = tmr_out[1];

   // ----------------------------------------
   // interrupt requests
   // ----------------------------------------
   assign first_timer_irq  = tmr_flag[0] & tmr_ie[0]; // [R19] [R22] [R14]
   assign second_timer_irq = tmr_flag[1] & tmr_ie[1]; // [R20] [R22] [R14]

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence psc_hit;
      ce && psc_match;
   endsequence

   sequence psc_restart;
      psc_count == 4'h0;
   endsequence

   psc_wrap_a: assert property (psc_hit |=> psc_restart) // [R17]
      else $error("prescaler did not restart after match");
   psc_stop_a: assert property (ce && !psc_run |=> psc_restart) // [R15]
      else $error("prescaler not cleared while unused");
   psc_inhibit_a: assert property (psc_src == dtim_pkg::PSC_SRC_INHIBIT |-> !psc_match) // [R16]
      else $error("prescaler matched with inhibited source");
   flag_set_a: assert property (ce && tmr_match[0] |=> tmr_flag[0]) // [R19]
      else $error("first flag lost on match");
   flag_second_a: assert property (ce && tmr_match[1] |=> tmr_flag[1]) // [R20]
      else $error("second flag lost on match");
   irq_drop_a: assert property ($fell(tmr_ie[0]) || $fell(tmr_flag[0]) |-> !first_timer_irq) // [R22]
      else $error("first irq held after flag or enable cleared");
   irq_gate_a: assert property (!tmr_ie[1] |-> !second_timer_irq) // [R14]
      else $error("second irq raised while disabled");
   flag_clear_a: assert property (flag_clr[0] && !tmr_match[0] |=> !tmr_flag[0]) // [R19]
      else $error("first flag not cleared by write");
   flag_keep_a: assert property (tmr_flag[1] && !flag_clr[1] |=> tmr_flag[1]) // [R20]
      else $error("second flag dropped without a clear");
   irq_raise_a: assert property (tmr_flag[0] && tmr_ie[0] |-> first_timer_irq) // [R22]
      else $error("first irq missing with flag and enable set");

endmodule

// >>> dual_16bit_interval_timers_tb.sv
/*
 * self-checking bench for dtim_top: apb tasks, register shadow, period model.
 * assumes a zero-wait apb slave (pready follows ce) and synchronous osc levels.
 */
`timescale 1ns/1ps
module dual_16bit_interval_timers_tb;
   // ----------------------------------------
   // signals and model state
   // ----------------------------------------
   logic        pclk, presetn, ce, psel, penable, pwrite;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pready, pslverr, first_oscillator, second_oscillator;
   logic        first_timer_output_pin, second_timer_output_pin;
   logic        first_timer_irq, second_timer_irq;
   int          miscompares = 0;
   int          num_checks  = 0;
   int          cyc         = 0;
   logic [7:0]  seed        = 8'h45;
   logic [15:0] idx_tab [6] = '{16'h7fa0, 16'h7fa1, 16'h7fa2, 16'h7fa3, 16'h7fa4, 16'h7fb6};
   logic [1:0]  srcs [3]    = '{2'h0, 2'h2, 2'h3};
   int          ratio [3]   = '{1, 4, 6};

   dtim_top i_dtim_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_oscillator(first_oscillator), .second_oscillator(second_oscillator),
      .first_timer_output_pin(first_timer_output_pin),
      .second_timer_output_pin(second_timer_output_pin),
      .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // oscillators: rising edge every 4 and every 6 cycles
   always @(posedge pclk) begin
      cyc               <= cyc + 1;
      first_oscillator  <= cyc[1];
      second_oscillator <= ((cyc % 6) < 3);
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction

   function automatic logic [7:0] ctl(input int t, input logic run, cksl, ie);
      logic [7:0] v;
      v = {4'h0, run, cksl, 1'b0, ie};
      return v << (4 * t);
   endfunction

   function automatic logic pin(input int t);
      return (t == 0) ? first_timer_output_pin : second_timer_output_pin;
   endfunction

   function automatic logic irq(input int t);
      return (t == 0) ? first_timer_irq : second_timer_irq;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one transfer: idle edge, setup, access held until pready
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                      input logic [3:0] strb, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      pstrb   <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, idx, d, 4'h1, r, e);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic eexp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, idx, 8'h00, 4'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, eexp});
   endtask

   task automatic wait_toggle(input int t, output int when);
      logic last;
      last = pin(t);
      do begin
         @(posedge pclk);
      end while (pin(t) === last);
      when = cyc;
   endtask

   task automatic period(input int t, input int exp);
      int a, b;
      wait_toggle(t, a);
      wait_toggle(t, b);
      chk(32'(b - a), 32'(exp));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under 20000 cycles
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      summarize();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int          t, a0, a, b, c;
      logic [7:0]  m, v, p;
      logic [31:0] r;
      logic        e;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({30'h0, first_timer_output_pin, second_timer_output_pin}, 32'h3);
      foreach (idx_tab[i]) rdchk(idx_tab[i], 32'h0, 1'b0);
      rdchk(16'h7fa5, 32'h0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         wr(idx_tab[i], v);
         rdchk(idx_tab[i], {24'h0, v}, 1'b0);
      end
      apb(1'b1, idx_tab[3], ~v, 4'h0, r, e);
      rdchk(idx_tab[3], {24'h0, v}, 1'b0);
      wr(16'h7fb6, 8'hff);
      rdchk(16'h7fb6, 32'hfd, 1'b0);
      wr(16'h7fa4, 8'h55);
      rdchk(16'h7fa4, 32'h55, 1'b0);
      wr(16'h7fa4, 8'h00);
      // system clock source, buffered reload while running
      for (t = 0; t < 2; t++) begin
         m = 8'h05 + (rnd() & 8'h0f);
         wr(idx_tab[2 * t], 8'h28);
         wr(idx_tab[2 * t + 1], 8'h00);
         wr(16'h7fa4, ctl(t, 1'b1, 1'b0, 1'b1));
         wait_toggle(t, a0);
         wait_toggle(t, a);
         chk(32'(a - a0), 32'd41);
         chk({31'h0, irq(t)}, 32'h1);
         wr(16'h7fa4, ctl(t, 1'b1, 1'b0, 1'b1));
         @(posedge pclk);
         chk({31'h0, irq(t)}, 32'h0);
         wr(idx_tab[2 * t], m);
         wait_toggle(t, b);
         chk(32'(b - a), 32'd41);
         wait_toggle(t, c);
         chk(32'(c - b), 32'(m) + 32'd1);
         // clock enable low for seven edges stretches the period by seven
         wait_toggle(t, a);
         ce <= 1'b0;
         repeat (7) @(posedge pclk);
         ce <= 1'b1;
         wait_toggle(t, b);
         chk(32'(b - a), 32'(m) + 32'd8);
         wr(16'h7fa4, ctl(t, 1'b1, 1'b0, 1'b0));
         wait_toggle(t, a);
         @(posedge pclk);
         chk({31'h0, irq(t)}, 32'h0);
         rdchk(16'h7fa4, {24'h0, ctl(t, 1'b1, 1'b0, 1'b0) | (8'h02 << (4 * t))}, 1'b0);
         wr(16'h7fa4, 8'h00);
         repeat (2) @(posedge pclk);
         chk({31'h0, pin(t)}, 32'h1);
      end
      // prescaler sources and periods
      for (int k = 0; k < 3; k++) begin
         p = rnd() & 8'h03;
         t = k & 1;
         wr(16'h7fb6, {p[3:0], srcs[k], 2'b00});
         wr(idx_tab[2 * t], 8'h03);
         wr(idx_tab[2 * t + 1], 8'h00);
         wr(16'h7fa4, ctl(t, 1'b0, 1'b1, 1'b0));
         wr(16'h7fa4, ctl(t, 1'b1, 1'b1, 1'b0));
         period(t, 4 * (int'(p) + 1) * ratio[k]);
         wr(16'h7fa4, ctl(t, 1'b0, 1'b1, 1'b0));
      end
      wr(16'h7fb6, 8'h04);
      wr(16'h7fa4, ctl(0, 1'b1, 1'b1, 1'b0));
      repeat (100) @(posedge pclk);
      chk({31'h0, first_timer_output_pin}, 32'h1);
      wr(16'h7fa4, ctl(0, 1'b0, 1'b1, 1'b0));
      summarize();
   end
endmodule
